// *** core/slpm_pkg.sv ***
// Constants, register map and state type for the serial line power mode control.
// Assumes a single 100 MHz clock and an APB register slave with 32-bit data.
package slpm_pkg;

    // ****************************************
    // Clock and timing
    // ****************************************
    localparam int CLK_PERIOD_NS   = 10;
    // Rail recovery after leaving power-down, least time, rounds up
    localparam int RECOVER_TIME_NS = 30000;
    localparam int RECOVER_CYCLES  = (RECOVER_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // Pump oscillator step period for a rate above 250 kHz, longest time, rounds down
    localparam int PUMP_STEP_NS    = 4000;
    localparam int PUMP_STEP_CYC   = PUMP_STEP_NS / CLK_PERIOD_NS;
    // Default standby entry delay in cycles
    localparam int STBY_CYC_DEF    = 1000;

    // ****************************************
    // Register map (byte addresses)
    // ****************************************
    localparam logic [11:0] ADDR_STATE = 12'h0_000;
    localparam logic [11:0] ADDR_STBY  = 12'h0_004;
    localparam logic [11:0] ADDR_ISTAT = 12'h0_008;
    localparam logic [11:0] ADDR_IMASK = 12'h0_00C;

    // State register fields
    localparam int ST_MODE_LSB   = 0;
    localparam int ST_PHASE_LSB  = 2;
    localparam int ST_PUMP_RUN   = 4;
    localparam int ST_RAILS_OK   = 5;
    localparam int ST_PRESENT    = 6;
    localparam int ST_VALID_LSB  = 7;
    localparam int ST_PDN_PIN    = 10;
    localparam int ST_WAKE_PIN   = 11;

    // Interrupt status and mask fields
    localparam int IRQ_W          = 4;
    localparam int IRQ_PRES_RISE  = 0;
    localparam int IRQ_PRES_FALL  = 1;
    localparam int IRQ_STBY_ENTRY = 2;
    localparam int IRQ_RAILS_OK   = 3;

    // Reset values
    localparam logic [IRQ_W-1:0] IMASK_RST = 4'h0;
    localparam logic [15:0]      STBY_RST  = 16'(STBY_CYC_DEF);

    // ****************************************
    // Pump phases and operating modes
    // ****************************************
    localparam logic [1:0] PH_NEG_STORE = 2'h0;
    localparam logic [1:0] PH_NEG_XFER  = 2'h1;
    localparam logic [1:0] PH_POS_STORE = 2'h2;
    localparam logic [1:0] PH_POS_XFER  = 2'h3;

    typedef enum logic [1:0] {
        MODE_DOWN,
        MODE_RECOVER,
        MODE_NORMAL,
        MODE_STANDBY
    } slpm_mode_t;

endpackage

// *** core/slpm_pump.sv ***
// Charge pump oscillator: four-phase sequencer with discontinuous run control.
// Assumes rail comparator levels arrive synchronous to mclk.
`timescale 1ns/10ps
module slpm_pump
    import slpm_pkg::*;
#(
    parameter int STEP_CYC = PUMP_STEP_CYC
) (
    // Clock and reset
    input  wire logic       mclk,
    input  wire logic       resetn,
    // Control and rail levels
    input  wire logic       pump_en,
    input  wire logic       rail_pos_ok,
    input  wire logic       rail_neg_ok,
    // Oscillator state
    output logic [1:0]      pump_phase,
    output logic            pump_run
);

    // ****************************************
    // Run decision and step timing
    // ****************************************
    logic [15:0] step_cnt;
    wire         rails_low  = ~(rail_pos_ok & rail_neg_ok);
    wire         step_done  = (step_cnt == 16'(STEP_CYC - 1));
    wire         pos_reg_ok = (pump_phase == PH_POS_XFER) & rail_pos_ok & rail_neg_ok;
    wire         stop_now   = ~pump_en | (step_done & pos_reg_ok);
    wire         start_now  = pump_en & rails_low & ~pump_run;

    // Oscillator enable and phase sequence
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            pump_run   <= 1'b0;
            pump_phase <= PH_NEG_STORE;
            step_cnt   <= 16'h0_000;
        end else if (stop_now) begin
            pump_run   <= 1'b0;
            pump_phase <= PH_NEG_STORE;
            step_cnt   <= 16'h0_000;
        end else if (start_now) begin
            pump_run   <= 1'b1;
        end else if (pump_run) begin
            step_cnt   <= step_done ? 16'h0_000 : step_cnt + 16'h0_001;
            if (step_done) begin
                pump_phase <= pump_phase + 2'h1;
            end
        end
    end

endmodule

// *** core/slpm_ctrl.sv ***
// Power mode control for a three-channel serial line transceiver, with APB registers.
// Assumes all pins synchronous to mclk; line validity comes from per-channel qualifiers.
//
// Design decisions made here: the register offsets and register access over APB.
`timescale 1ns/10ps
module slpm_ctrl
    import slpm_pkg::*;
#(
    parameter int CHANNELS = 3,
    parameter int STBY_CYC = STBY_CYC_DEF,
    parameter int STEP_CYC = PUMP_STEP_CYC
) (
    // Clock and reset
    input  wire logic                mclk,
    input  wire logic                resetn,
    // APB slave
    input  wire logic                psel,
    input  wire logic                penable,
    input  wire logic                pwrite,
    input  wire logic [11:0]         paddr,
    input  wire logic [31:0]         pwdata,
    output logic [31:0]              prdata,
    output logic                     pready,
    output logic                     pslverr,
    // Mode control pins
    input  wire logic                power_down_n,
    input  wire logic                wake_ctrl,
    // Host side logic
    input  wire logic [CHANNELS-1:0] driver_logic_in,
    output logic [CHANNELS-1:0]      receiver_logic_out,
    output logic [CHANNELS-1:0]      receiver_oe,
    // Line side
    input  wire logic [CHANNELS-1:0] line_receive_in,
    input  wire logic [CHANNELS-1:0] line_valid,
    output logic [CHANNELS-1:0]      line_drive_out,
    output logic [CHANNELS-1:0]      line_drive_oe,
    // Rail comparators and pump
    input  wire logic                rail_pos_ok,
    input  wire logic                rail_neg_ok,
    output logic [1:0]               pump_phase,
    output logic                     pump_run,
    output logic                     rails_valid,
    // Status and interrupt
    output logic                     line_present,
    output logic                     irq
);

    // ****************************************
    // Declarations
    // ****************************************
    slpm_mode_t          mode;
    slpm_mode_t          next_mode;
    logic [15:0]         rec_cnt;
    logic [15:0]         idle_cnt;
    logic [15:0]         stby_dly;
    logic [IRQ_W-1:0]    irq_stat;
    logic [IRQ_W-1:0]    irq_mask;
    logic                present_d;
    logic                rails_d;

    // ****************************************
    // Mode decisions
    // ****************************************
    // Automatic wake only while not forced down
    wire auto_wake   = ~wake_ctrl & power_down_n;
    wire forced_on   = wake_ctrl & power_down_n;
    wire rec_done    = (rec_cnt == 16'(RECOVER_CYCLES - 1));
    wire idle_over   = (idle_cnt >= stby_dly);
    wire idle_count  = (mode == MODE_NORMAL) & auto_wake & ~line_present;
    wire any_valid   = |line_valid;

    // Next operating mode
    always_comb begin
        next_mode = mode;
        if (!power_down_n) begin
            next_mode = MODE_DOWN;
        end else begin
            case (mode)
                MODE_DOWN: begin
                    next_mode = MODE_RECOVER;
                end
                MODE_RECOVER: begin
                    if (rec_done) begin
                        next_mode = MODE_NORMAL;
                    end
                end
                MODE_NORMAL: begin
                    if (forced_on) begin
                        next_mode = MODE_NORMAL;
                    end else if (line_present) begin
                        next_mode = MODE_NORMAL;
                    end else if (idle_over) begin
                        next_mode = MODE_STANDBY;
                    end
                end
                MODE_STANDBY: begin
                    if (line_present || !auto_wake) begin
                        next_mode = MODE_RECOVER;
                    end
                end
                default: begin
                    next_mode = MODE_DOWN;
                end
            endcase
        end
    end

    // Mode register
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            mode <= MODE_DOWN;
        end else begin
            mode <= next_mode;
        end
    end

    // Recovery timer, restarts on each entry
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            rec_cnt <= 16'h0_000;
        end else if (mode != MODE_RECOVER) begin
            rec_cnt <= 16'h0_000;
        end else if (!rec_done) begin
            rec_cnt <= rec_cnt + 16'h0_001;
        end
    end

    // Idle timer toward standby, saturating
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            idle_cnt <= 16'h0_000;
        end else if (!idle_count) begin
            idle_cnt <= 16'h0_000;
        end else if (!idle_over) begin
            idle_cnt <= idle_cnt + 16'h0_001;
        end
    end

    // ****************************************
    // Line presence and data paths
    // ****************************************
    // Presence follows the qualifiers in every mode
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            line_present <= 1'b0;
        end else begin
            line_present <= any_valid;
        end
    end

    // Output enables by mode
    wire drv_on = (mode == MODE_NORMAL);
    wire rcv_on = (mode != MODE_DOWN);

    // Inverting drivers and receivers, parked low while floated
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            line_drive_out     <= '0;
            line_drive_oe      <= '0;
            receiver_logic_out <= '0;
            receiver_oe        <= '0;
        end else begin
            line_drive_out     <= drv_on ? ~driver_logic_in : '0;
            line_drive_oe      <= {CHANNELS{drv_on}};
            receiver_logic_out <= rcv_on ? ~line_receive_in : '0;
            receiver_oe        <= {CHANNELS{rcv_on}};
        end
    end

    // Rails flagged valid only once recovery is complete
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            rails_valid <= 1'b0;
        end else begin
            rails_valid <= (next_mode == MODE_NORMAL);
        end
    end

    // ****************************************
    // Charge pump
    // ****************************************
    wire pump_en = (mode == MODE_RECOVER) | (mode == MODE_NORMAL);

    slpm_pump #(
        .STEP_CYC    (STEP_CYC)
    ) u_pump (
        .mclk        (mclk),
        .resetn      (resetn),
        .pump_en     (pump_en),
        .rail_pos_ok (rail_pos_ok),
        .rail_neg_ok (rail_neg_ok),
        .pump_phase  (pump_phase),
        .pump_run    (pump_run)
    );

    // ****************************************
    // Events and interrupt
    // ****************************************
    // Previous values for edge detection
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            present_d <= 1'b0;
            rails_d   <= 1'b0;
        end else begin
            present_d <= line_present;
            rails_d   <= rails_valid;
        end
    end

    wire [IRQ_W-1:0] irq_evt;
    assign irq_evt[IRQ_PRES_RISE]  = line_present & ~present_d;
    assign irq_evt[IRQ_PRES_FALL]  = ~line_present & present_d;
    assign irq_evt[IRQ_STBY_ENTRY] = (next_mode == MODE_STANDBY) & (mode != MODE_STANDBY);
    assign irq_evt[IRQ_RAILS_OK]   = rails_valid & ~rails_d;

    // ****************************************
    // APB slave
    // ****************************************
    wire setup_ph  = psel & ~penable;
    wire access_wr = psel & penable & pwrite;
    wire hit_state = (paddr == ADDR_STATE);
    wire hit_stby  = (paddr == ADDR_STBY);
    wire hit_istat = (paddr == ADDR_ISTAT);
    wire hit_imask = (paddr == ADDR_IMASK);
    wire hit_any   = hit_state | hit_stby | hit_istat | hit_imask;

    // State word as seen by software
    wire [31:0] state_word;
    assign state_word[ST_MODE_LSB +: 2]          = mode;
    assign state_word[ST_PHASE_LSB +: 2]         = pump_phase;
    assign state_word[ST_PUMP_RUN]               = pump_run;
    assign state_word[ST_RAILS_OK]               = rails_valid;
    assign state_word[ST_PRESENT]                = line_present;
    assign state_word[ST_VALID_LSB +: CHANNELS]  = line_valid;
    assign state_word[ST_PDN_PIN]                = power_down_n;
    assign state_word[ST_WAKE_PIN]               = wake_ctrl;
    assign state_word[31:ST_WAKE_PIN+1]          = '0;

    // Read mux, unmapped reads as zero
    wire [31:0] rd_word = hit_state ? state_word :
                          hit_stby  ? {16'h0_000, stby_dly} :
                          hit_istat ? {{(32-IRQ_W){1'b0}}, irq_stat} :
                          hit_imask ? {{(32-IRQ_W){1'b0}}, irq_mask} :
                          32'h0000_0000;

    // Zero-wait answer in the access phase
    assign pready = 1'b1;

    // Read data and error captured during setup
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else if (setup_ph) begin
            prdata  <= pwrite ? 32'h0000_0000 : rd_word;
            pslverr <= ~hit_any;
        end
    end

    // Writable configuration
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            stby_dly <= STBY_RST;
            irq_mask <= IMASK_RST;
        end else if (access_wr) begin
            if (hit_stby) begin
                stby_dly <= pwdata[15:0];
            end
            if (hit_imask) begin
                irq_mask <= pwdata[IRQ_W-1:0];
            end
        end
    end

    // Sticky status, write one to clear, set wins over clear
    wire [IRQ_W-1:0] irq_clr = (access_wr & hit_istat) ? pwdata[IRQ_W-1:0] : '0;

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            irq_stat <= '0;
        end else begin
            irq_stat <= (irq_stat & ~irq_clr) | irq_evt;
        end
    end

    // Level interrupt from unmasked sticky bits
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            irq <= 1'b0;
        end else begin
            irq <= |(((irq_stat & ~irq_clr) | irq_evt) & irq_mask);
        end
    end

endmodule

// *** verif/slpm_asserts.sv ***
// Port checker for the serial line power mode control.
// Assumes bind into slpm_ctrl with three channels and its STEP_CYC.
`timescale 1ns/10ps
module slpm_asserts
    import slpm_pkg::*;
#(
    parameter int STEP_CYC = PUMP_STEP_CYC
) (
    // Clock and reset
    input wire logic       mclk,
    input wire logic       resetn,
    // Mode pins and line side
    input wire logic       power_down_n,
    input wire logic       wake_ctrl,
    input wire logic [2:0] driver_logic_in,
    input wire logic [2:0] line_receive_in,
    input wire logic [2:0] line_valid,
    input wire logic [2:0] receiver_logic_out,
    input wire logic [2:0] receiver_oe,
    input wire logic [2:0] line_drive_out,
    input wire logic [2:0] line_drive_oe,
    // Pump and status
    input wire logic       rail_pos_ok,
    input wire logic       rail_neg_ok,
    input wire logic [1:0] pump_phase,
    input wire logic       pump_run,
    input wire logic       rails_valid,
    input wire logic       line_present
);
    // ****
    // Helper counters
    // ****
    int         pd_cnt;
    int         ph_cnt;
    logic [1:0] last_ph;
    default clocking @(posedge mclk); endclocking
    default disable iff (!resetn);
    // Cycles since power-down released, cycles a phase is held
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            pd_cnt  <= 0;
            ph_cnt  <= 0;
            last_ph <= 2'h0;
        end else begin
            pd_cnt  <= power_down_n ? pd_cnt + 1 : 0;
            ph_cnt  <= (pump_phase != last_ph) ? 1 : ph_cnt + 1;
            last_ph <= pump_phase;
        end
    end
    // ****
    // Assertions
    // ****
    AST_PDN_FLOAT: assert property (!power_down_n [*3] |-> !line_drive_oe && !receiver_oe)
        else $error("outputs driven in power-down");
    AST_PDN_PUMP: assert property (!power_down_n [*3] |-> !pump_run && !rails_valid)
        else $error("pump running in power-down");
    AST_PRESENT: assert property ($past(resetn) |-> line_present == $past(|line_valid))
        else $error("line presence wrong");
    AST_RX_INV: assert property ($past(resetn) |->
        receiver_logic_out == (~$past(line_receive_in) & receiver_oe))
        else $error("receiver output wrong");
    AST_TX_INV: assert property ($past(resetn) |->
        line_drive_out == (~$past(driver_logic_in) & line_drive_oe))
        else $error("driver output wrong");
    AST_ALWAYS_ON: assert property (rails_valid && wake_ctrl && power_down_n |=>
        rails_valid && line_drive_oe == 3'h7 && receiver_oe == 3'h7)
        else $error("left normal with wake control high");
    AST_RECOVER: assert property ($rose(rails_valid) |-> pd_cnt >= RECOVER_CYCLES)
        else $error("rails valid too early");
    AST_PH_STEP: assert property (pump_run && $past(pump_run) && pump_phase != last_ph
        |-> pump_phase == 2'(last_ph + 2'h1))
        else $error("pump phase out of order");
    AST_PH_TIME: assert property (pump_run && pump_phase != last_ph &&
        last_ph != PH_NEG_STORE |-> ph_cnt == STEP_CYC)
        else $error("pump step length wrong");
    AST_PUMP_STOP: assert property ($fell(pump_run) && wake_ctrl && $past(wake_ctrl) &&
        $past(power_down_n) && $past(power_down_n, 2) |-> $past(pump_phase) == PH_POS_XFER
        && $past(rail_pos_ok && rail_neg_ok))
        else $error("pump stopped out of regulation");
    AST_PUMP_RUN: assert property ((power_down_n && wake_ctrl && rails_valid &&
        !rail_pos_ok) [*3] |-> pump_run)
        else $error("pump idle with rail low");
    // Main scenarios
    C_RECOVER: cover property ($rose(rails_valid));
    C_STANDBY: cover property (receiver_oe == 3'h7 && !line_drive_oe && power_down_n);
    C_PUMP_STOP: cover property ($fell(pump_run));
endmodule

bind slpm_ctrl slpm_asserts #(.STEP_CYC(STEP_CYC)) i_asserts (.*);

// *** verif/slpm_line_model.sv ***
// Remote line equipment and rail storage beside the transceiver.
// Assumes the mclk domain; connected and rx_pat come from the bench.
`timescale 1ns/10ps
module slpm_line_model (
    // Clock and reset
    input  wire logic       mclk,
    input  wire logic       resetn,
    // Bench controls
    input  wire logic       connected,
    input  wire logic [2:0] rx_pat,
    // Device side
    input  wire logic       pump_run,
    input  wire logic [2:0] receiver_oe,
    output logic [2:0]      line_receive_in,
    output logic [2:0]      line_valid,
    output logic            rail_pos_ok,
    output logic            rail_neg_ok
);
    int level;
    int tick;
    // Open cable pulled low, no valid level
    assign line_receive_in = connected ? rx_pat : 3'h0;
    assign line_valid      = {3{connected}};
    // Rails regulated once charged
    assign rail_pos_ok = level >= 32;
    assign rail_neg_ok = level >= 30;
    // Pump charges, idle leaks, power-down empties at once
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            level <= 0;
            tick  <= 0;
        end else begin
            tick <= tick + 1;
            if (receiver_oe == 3'h0) begin
                level <= 0;
            end else if (pump_run) begin
                level <= level + int'(level < 40);
            end else if (tick % 16 == 0 && level > 0) begin
                level <= level - 1;
            end
        end
    end
endmodule

// *** verif/testbench.sv ***
// Self-checking bench for the serial line power mode control.
// Assumes slpm_pkg, the line model and the checker are compiled first.
`timescale 1ns/10ps
module testbench;
    import slpm_pkg::*;
    typedef struct packed {
        logic       pdn, wake, conn;
        logic [1:0] mode;
        logic       txoe, rxoe, pres;
    } slpm_tb_row_t;
    logic        mclk, resetn, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic        power_down_n, wake_ctrl, connected, er;
    logic        rail_pos_ok, rail_neg_ok, pump_run, rails_valid, line_present, irq;
    logic [2:0]  driver_logic_in, receiver_logic_out, receiver_oe, line_receive_in;
    logic [2:0]  line_valid, line_drive_out, line_drive_oe, rx_pat, ex;
    logic [1:0]  pump_phase;
    logic [3:0]  seen;
    int          bad_count, compares, n;
    slpm_tb_row_t rows [6] = '{
        '{1'b1, 1'b1, 1'b1, MODE_NORMAL, 1'b1, 1'b1, 1'b1},
        '{1'b1, 1'b1, 1'b0, MODE_NORMAL, 1'b1, 1'b1, 1'b0},
        '{1'b1, 1'b0, 1'b1, MODE_NORMAL, 1'b1, 1'b1, 1'b1},
        '{1'b1, 1'b0, 1'b0, MODE_STANDBY, 1'b0, 1'b1, 1'b0},
        '{1'b0, 1'b1, 1'b1, MODE_DOWN, 1'b0, 1'b0, 1'b1},
        '{1'b0, 1'b0, 1'b0, MODE_DOWN, 1'b0, 1'b0, 1'b0}};
    slpm_ctrl #(.STEP_CYC(4)) i_dut (.*);
    slpm_line_model i_line (.*);
    // ****
    // Tasks
    // ****
    task automatic tally_and_finish();
        $display("compares=%0d bad_count=%0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            bad_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // One APB transfer, idle edge first
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int k;
        @(posedge mclk);
        psel    <= 1'b1;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge mclk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge mclk);
            k++;
        end while (pready !== 1'b1 && k < 50);
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        if (k >= 50) begin
            bad_count++;
            tally_and_finish();
        end
    endtask
    task automatic wait_mode(input logic [1:0] m);
        int k;
        k = 0;
        do begin
            apb(1'b0, ADDR_STATE, 32'h0000_0000);
            k++;
        end while (rd[1:0] !== m && k < 3000);
        if (rd[1:0] !== m) begin
            bad_count++;
            tally_and_finish();
        end
    endtask
    // ****
    // Clock and phase monitor
    // ****
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    always @(posedge mclk) if (pump_run === 1'b1) seen[pump_phase] <= 1'b1;
    // ****
    // Main sequence
    // ****
    initial begin
        {resetn, psel, penable, pwrite, power_down_n, wake_ctrl, connected} = 7'h00;
        paddr           = 12'h000;
        pwdata          = 32'h0000_0000;
        driver_logic_in = 3'h3;
        rx_pat          = 3'h6;
        seen            = 4'h0;
        bad_count       = 0;
        compares        = 0;
        repeat (10) @(posedge mclk);
        resetn <= 1'b1;
        apb(1'b1, ADDR_STBY, 32'h0000_0014);
        foreach (rows[i]) begin
            power_down_n <= rows[i].pdn;
            wake_ctrl    <= rows[i].wake;
            connected    <= rows[i].conn;
            wait_mode(rows[i].mode);
            repeat (3) @(posedge mclk);
            ex = rows[i].conn ? rx_pat : 3'h0;
            chk(32'({line_drive_oe, receiver_oe, line_present}),
                32'({{3{rows[i].txoe}}, {3{rows[i].rxoe}}, rows[i].pres}));
            chk(32'(receiver_logic_out), 32'(~ex & {3{rows[i].rxoe}}));
            chk(32'(line_drive_out), 32'(~driver_logic_in & {3{rows[i].txoe}}));
        end
        chk(32'(seen), 32'h0000_000F);
        // Second reset: outputs low, register reset values, unmapped refusal, accepted state write
        resetn <= 1'b0;
        repeat (10) @(posedge mclk);
        chk(32'({line_drive_oe, receiver_oe, rails_valid, pump_run, irq}), 32'h0);
        resetn <= 1'b1;
        apb(1'b0, ADDR_STBY, 32'h0000_0000);
        chk(rd, 32'(STBY_RST));
        apb(1'b0, ADDR_IMASK, 32'h0000_0000);
        chk(rd, 32'(IMASK_RST));
        apb(1'b0, 12'h010, 32'h0000_0000);
        chk(32'({er, rd[30:0]}), 32'h8000_0000);
        apb(1'b1, ADDR_STATE, 32'hFFFF_FFFF);
        chk(32'(er), 32'h0000_0000);
        // Recovery time from power-down release
        power_down_n <= 1'b1;
        wake_ctrl    <= 1'b1;
        n = 0;
        do begin
            @(posedge mclk);
            n++;
        end while (rails_valid !== 1'b1 && n < 4000);
        chk(32'(n >= RECOVER_CYCLES && n <= RECOVER_CYCLES + 3), 32'h1);
        // Standby delay, then interrupt raise, mask and clear
        apb(1'b1, ADDR_STBY, 32'h0000_0014);
        apb(1'b1, ADDR_ISTAT, 32'h0000_000F);
        wake_ctrl <= 1'b0;
        repeat (15) @(posedge mclk);
        chk(32'(line_drive_oe), 32'h7);
        repeat (15) @(posedge mclk);
        chk(32'({line_drive_oe, receiver_oe}), 32'h07);
        apb(1'b0, ADDR_ISTAT, 32'h0000_0000);
        chk(rd, 32'h0000_0004);
        for (int j = 0; j < 4; j++) begin
            if (j == 3) apb(1'b1, ADDR_ISTAT, 32'h0000_0004);
            else apb(1'b1, ADDR_IMASK, (j == 1) ? 32'h0 : 32'h0000_0004);
            repeat (2) @(posedge mclk);
            chk(32'(irq), 32'(j % 2 == 0));
        end
        tally_and_finish();
    end
endmodule
